// *** wtw_params.svh ***
// timing constants and limits for the wakeup timer watchdog
`ifndef WTW_PARAMS_SVH
`define WTW_PARAMS_SVH

`define WTW_CLK_PERIOD_NS   8
`define WTW_OSC_PERIOD_NS   10_000_000
`define WTW_TICK_MS         10
`define WTW_DEADLINE_MS     20
`define WTW_WAKE_MS         20
`define WTW_RESET_MS        320
`define WTW_VALID_MS        20
`define WTW_OBSERVE_MS      30
`define WTW_DEBOUNCE_MS     20
`define WTW_IVAL_MIN_MS     100
`define WTW_IVAL_MAX_S      7200
`define WTW_IVAL_W          20
`define WTW_GCNT_W          8

`endif

// *** wtw_pkg.sv ***
// types shared by the wakeup timer watchdog modules
package wtw_pkg;
  `include "wtw_params.svh"

  typedef enum logic [4:0]
  {
    ST_MEASURE  = 5'h01,
    ST_RUN      = 5'h02,
    ST_RESET    = 5'h04,
    ST_MANUAL   = 5'h08,
    ST_DEBOUNCE = 5'h10
  } wtw_state_e;

  typedef struct packed
  {
    logic                   valid;
    logic [`WTW_IVAL_W-1:0] count;
  } wtw_conv_s;
endpackage

// *** wtw_tick_div.sv ***
// divider making the internal oscillator tick as a one-cycle enable
`timescale 1ns/1ns
module wtw_tick_div #(
  parameter int unsigned DIV = 1_250_000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // tick enable
  output logic      tick
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick  <= (cnt_r == CW'(DIV - 1));
      cnt_r <= (cnt_r == CW'(DIV - 1)) ? '0 : cnt_r + 1'b1;
    end
  end
endmodule

// *** wtw_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module wtw_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// *** wtw_top.sv ***
// wakeup timer with watchdog, manual reset and one-time interval capture
// Notes on behaviour
// (R1) controller raises completion at least 20 ms before the next wakeup rise
// (R2) missing completion by the deadline pulls the reset output low at interval start
// (R3) wakeup pulse at each interval start, not the first, not after a miss
// (R4) wakeup output stays low when no pulse is issued
// (R5) only a rising completion edge counts, first one per interval
// (R6) completion clears only the watchdog state and drops a high wakeup at once
// (R7) reset output low during power-on reset and interval reading
// (R8) pin high for two oscillator ticks asserts the reset output
// (R9) interval measured once after power-on and kept until next power-up
// (R10) manual reset or missed deadline asserts reset and restarts the interval, wakeup and state counters
// (R11) interval selectable from 100 ms to 7200 s
// (R12) reset fall to next wakeup rise is interval plus reset width; to next reset fall, two intervals plus reset width
// (R13) manual reset during reading aborts it; reading restarts after release plus debounce
// (R14) manual reset valid only if high 20 ms within a 30 ms observation
// (R15) manual reset clears counters; restart after release plus debounce and reset width
// (R16) reset low after validation delay, held through release, debounce, reset width
// (R17) valid manual reset forces wakeup low and reset output low
// (R18) completion at least 100 ns after wakeup or reset, by interval minus 20 ms
// (R19) after reading, the pin serves only as a digital manual reset input
// (R20) wakeup and reset widths are fixed tick counts, wakeup much shorter
// (R21) measured interval arrives as a count, latched once and held
`timescale 1ns/1ns
`include "wtw_params.svh"
module wtw_top
  import wtw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `WTW_OSC_PERIOD_NS / `WTW_CLK_PERIOD_NS
) (
  // clock and power-on reset
  input  wire logic      clk,
  input  wire logic      rst,
  // pins from the controller and the interval/manual reset pin
  input  wire logic      task_complete_in,
  input  wire logic      interval_set_manual_reset_pin,
  // result of the interval conversion
  input  wire wtw_conv_s conv_in,
  // outputs
  output logic           wakeup_pulse_out,
  output logic           watchdog_reset_n_out,
  output logic           measure_enable_out
);
  localparam int unsigned IW = `WTW_IVAL_W;
  localparam int unsigned GW = `WTW_GCNT_W;
  localparam int unsigned DEADLINE_TICKS = `WTW_DEADLINE_MS / `WTW_TICK_MS;
  localparam int unsigned WAKE_TICKS = `WTW_WAKE_MS / `WTW_TICK_MS;
  localparam int unsigned RESET_TICKS = (`WTW_RESET_MS + `WTW_TICK_MS - 1) / `WTW_TICK_MS;
  localparam int unsigned VALID_TICKS = (`WTW_VALID_MS + `WTW_TICK_MS - 1) / `WTW_TICK_MS;
  localparam int unsigned OBSERVE_TICKS = `WTW_OBSERVE_MS / `WTW_TICK_MS;
  localparam int unsigned DEB_TICKS = (`WTW_DEBOUNCE_MS + `WTW_TICK_MS - 1) / `WTW_TICK_MS;
  localparam int unsigned IVAL_MIN = `WTW_IVAL_MIN_MS / `WTW_TICK_MS;
  localparam int unsigned IVAL_MAX = `WTW_IVAL_MAX_S * 1000 / `WTW_TICK_MS;

  // clamp the converted count to the selectable range
  function automatic logic [IW-1:0] clamp_ival(input logic [IW-1:0] c);
    if (c < IW'(IVAL_MIN))
      return IW'(IVAL_MIN);
    else if (c > IW'(IVAL_MAX))
      return IW'(IVAL_MAX);
    else
      return c;
  endfunction

  logic          tick;
  logic          done_s;
  logic          pin_s;
  logic          done_d_r;
  logic          done_edge;
  logic          done_take;
  wtw_state_e    state_r;
  wtw_state_e    state_nxt;
  logic [GW-1:0] gcnt_r;
  logic [GW-1:0] obs_r;
  logic          mr_valid;
  logic [IW-1:0] ival_r;
  logic [IW-1:0] ival_cnt_r;
  logic          measured_r;
  logic          first_r;
  logic          done_taken_r;
  logic          done_ok_r;
  logic          boundary;
  logic          miss;
  logic [GW-1:0] wake_cnt_r;
  logic [GW-1:0] deb_end;

  wtw_tick_div #(
    .DIV (TICK_CYCLES)
  ) u_div (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  wtw_sync #(
    .W (2)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({task_complete_in, interval_set_manual_reset_pin}),
    .q   ({done_s, pin_s})
  );

  // completion edge detection
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      done_d_r <= 1'b0;
    else
      done_d_r <= done_s;
  end

  assign done_edge = done_s & ~done_d_r;                       // see (R5)
  assign done_take = done_edge & ~done_taken_r & (state_r == ST_RUN); // see (R5)

  // manual reset qualification by counting consecutive high ticks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      obs_r <= '0;
    else if (tick)
      obs_r <= pin_s ? ((obs_r == GW'(OBSERVE_TICKS)) ? obs_r : obs_r + 1'b1) : '0;
  end

  // pin high on VALID_TICKS consecutive ticks inside the observation window
  assign mr_valid = tick & pin_s & (obs_r == GW'(VALID_TICKS - 1)); // see (R8) see (R14)

  assign boundary = (state_r == ST_RUN) & tick & (ival_cnt_r == ival_r - 1'b1);
  assign miss     = boundary & ~first_r & ~done_ok_r;          // see (R2)
  assign deb_end  = measured_r ? GW'(DEB_TICKS + RESET_TICKS - 1) : GW'(DEB_TICKS - 1);

  // next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_MEASURE:
      begin
        if (mr_valid)
          state_nxt = ST_MANUAL;                               // see (R13)
        else if (conv_in.valid)
          state_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        if (mr_valid)
          state_nxt = ST_MANUAL;                               // see (R10)
        else if (miss)
          state_nxt = ST_RESET;                                // see (R2) see (R10)
      end
      ST_RESET:
      begin
        if (mr_valid)
          state_nxt = ST_MANUAL;
        else if (tick && gcnt_r == GW'(RESET_TICKS - 1))
          state_nxt = ST_RUN;                                  // see (R12)
      end
      ST_MANUAL:
      begin
        if (tick && !pin_s)
          state_nxt = ST_DEBOUNCE;                             // see (R15)
      end
      ST_DEBOUNCE:
      begin
        if (tick && pin_s)
          state_nxt = ST_MANUAL;
        else if (tick && gcnt_r == deb_end)
          state_nxt = measured_r ? ST_RUN : ST_MEASURE;        // see (R13) see (R16)
      end
    endcase
  end

  // state and the shared tick counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_MEASURE;
      gcnt_r  <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        gcnt_r <= '0;                                          // see (R15)
      else if (tick)
        gcnt_r <= gcnt_r + 1'b1;
    end
  end

  // one-time interval capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ival_r     <= IW'(IVAL_MIN);
      measured_r <= 1'b0;
    end
    else if (state_r == ST_MEASURE && state_nxt == ST_RUN)
    begin
      ival_r     <= clamp_ival(conv_in.count);                 // see (R9) see (R11) see (R21)
      measured_r <= 1'b1;
    end
  end

  // interval counter and completion tracking
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ival_cnt_r   <= '0;
      first_r      <= 1'b1;
      done_taken_r <= 1'b0;
      done_ok_r    <= 1'b0;
    end
    else if (state_r != ST_RUN || state_nxt != ST_RUN)
    begin
      ival_cnt_r   <= '0;                                      // see (R10) see (R15)
      first_r      <= 1'b1;                                    // see (R3)
      done_taken_r <= 1'b0;
      done_ok_r    <= 1'b0;
    end
    else if (boundary)
    begin
      ival_cnt_r   <= '0;
      first_r      <= 1'b0;
      done_taken_r <= done_edge;
      done_ok_r    <= done_edge;
    end
    else
    begin
      if (tick)
        ival_cnt_r <= ival_cnt_r + 1'b1;                       // see (R6)
      if (done_take)
      begin
        done_taken_r <= 1'b1;                                  // see (R5)
        done_ok_r    <= (ival_cnt_r < ival_r - IW'(DEADLINE_TICKS)); // see (R1) see (R18)
      end
    end
  end

  // wakeup pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wakeup_pulse_out <= 1'b0;
      wake_cnt_r       <= '0;
    end
    else if (state_nxt != ST_RUN)
    begin
      wakeup_pulse_out <= 1'b0;                                // see (R17)
      wake_cnt_r       <= '0;
    end
    else if (boundary)
    begin
      wakeup_pulse_out <= 1'b1;                                // see (R3)
      wake_cnt_r       <= '0;
    end
    else if (wakeup_pulse_out)
    begin
      if (done_take || (tick && wake_cnt_r == GW'(WAKE_TICKS - 1)))
        wakeup_pulse_out <= 1'b0;                              // see (R4) see (R6) see (R20)
      if (tick)
        wake_cnt_r <= wake_cnt_r + 1'b1;
    end
  end

  // reset output and measurement path enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      watchdog_reset_n_out <= 1'b0;                            // see (R7)
      measure_enable_out   <= 1'b0;
    end
    else
    begin
      watchdog_reset_n_out <= (state_nxt == ST_RUN);           // see (R7) see (R16) see (R17)
      measure_enable_out   <= (state_nxt == ST_MEASURE);       // see (R13) see (R19)
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_watchdog_reset_n_out_measure_low: assert property (                        // see (R7)
    (state_r == ST_MEASURE) |-> !watchdog_reset_n_out)
    else $error("reset output high during interval reading");

  a_miss_asserts_rst: assert property (                        // see (R2)
    (miss && !mr_valid) |=> (!watchdog_reset_n_out && state_r == ST_RESET))
    else $error("missed completion did not assert reset");

  a_wake_at_boundary: assert property (                        // see (R3)
    $rose(wakeup_pulse_out) |-> $past(boundary && !miss))
    else $error("wakeup rose outside an interval start");

  a_wake_only_run: assert property (                           // see (R4)
    wakeup_pulse_out |-> (watchdog_reset_n_out && state_r == ST_RUN))
    else $error("wakeup high while not running");

  a_done_drops_wake: assert property (                         // see (R6)
    (done_take && wakeup_pulse_out && !boundary) |=> !wakeup_pulse_out)
    else $error("completion did not drop wakeup");

  a_first_edge_only: assert property (                         // see (R5)
    (state_r == ST_RUN && done_taken_r && !boundary && state_nxt == ST_RUN)
      |=> $stable(done_ok_r))
    else $error("later completion edge was acted on");

  a_manual_forces: assert property (                           // see (R8)
    mr_valid |=> (!watchdog_reset_n_out && !wakeup_pulse_out && state_r == ST_MANUAL))
    else $error("valid manual reset did not force outputs");

  a_abort_reading: assert property (                           // see (R13)
    (state_r == ST_MEASURE && mr_valid) |=> !measure_enable_out ##1 !measure_enable_out)
    else $error("reading not aborted by manual reset");

  a_interval_held: assert property (                           // see (R9)
    (measured_r && $past(measured_r)) |-> $stable(ival_r))
    else $error("interval changed after capture");

  a_meas_only_reading: assert property (                       // see (R19)
    measure_enable_out |-> (state_r == ST_MEASURE && !measured_r))
    else $error("measurement path enabled after reading");

  a_interval_range: assert property (                          // see (R11)
    measured_r |-> (ival_r >= IW'(IVAL_MIN) && ival_r <= IW'(IVAL_MAX)))
    else $error("interval outside selectable range");

  a_wake_width: assert property (                              // see (R20)
    wakeup_pulse_out |-> (wake_cnt_r < GW'(WAKE_TICKS)))
    else $error("wakeup pulse longer than its width");

  a_reset_width: assert property (                             // see (R12)
    (state_r == ST_RESET) |-> (gcnt_r < GW'(RESET_TICKS)))
    else $error("reset pulse longer than its width");

  c_wake_issued:   cover property ($rose(wakeup_pulse_out));
  c_miss_reset:    cover property (miss);
  c_manual_reset:  cover property (mr_valid && state_r == ST_RUN);
  c_abort_reading: cover property (mr_valid && state_r == ST_MEASURE);
endmodule

// *** wtw_mcu_model.sv ***
// controller stand-in that answers each wakeup with a completion edge
`timescale 1ns/1ns
module wtw_mcu_model (
  // clock
  input  wire logic        clk,
  // wakeup from the timer
  input  wire logic        wakeup_pulse_out,
  // answer delay in cycles after the wakeup rise, zero keeps it silent
  input  wire logic [15:0] delay,
  // completion pin
  output logic             task_complete_in
);
  logic wake_q = 1'b0;
  int   cnt    = -8;

  always @(posedge clk)
  begin
    wake_q <= wakeup_pulse_out;
    // delay is kept at 13 cycles or more, over 100 ns after the rise
    if (wakeup_pulse_out === 1'b1 && wake_q === 1'b0 && delay != 16'h0000)
      cnt <= int'(delay);
    else if (cnt > -8)
      cnt <= cnt - 1;
    task_complete_in <= (cnt <= 0 && cnt > -6);
  end
endmodule

// *** tb_wtw_top.sv ***
// testbench for the wakeup timer watchdog
`timescale 1ns/1ns
module tb_wtw_top;
  import wtw_pkg::*;
  localparam int TK = 16;
  localparam int IV = 10 * TK;
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic        pin         = 1'b0;
  wtw_conv_s   conv        = '0;
  logic [15:0] dly         = 16'h003c;
  logic        done;
  logic        wake;
  logic        rst_n;
  logic        meas;
  int          err_count   = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  int          t_cap;
  int          t_rel;
  // wake rise, wake width, reset fall, reset rise
  int          ev [4];
  logic        wk_q        = 1'b0;
  logic        rs_q        = 1'b0;

  always #4 clk = ~clk;

  wtw_top #(.TICK_CYCLES(TK)) dut_u (.clk(clk), .rst(rst), .task_complete_in(done),
    .interval_set_manual_reset_pin(pin), .conv_in(conv), .wakeup_pulse_out(wake),
    .watchdog_reset_n_out(rst_n), .measure_enable_out(meas));

  wtw_mcu_model mcu_u (.clk(clk), .wakeup_pulse_out(wake), .delay(dly),
    .task_complete_in(done));

  always @(posedge clk)
  begin
    cyc  <= cyc + 1;
    wk_q <= wake;
    rs_q <= rst_n;
    if (wake === 1'b1 && wk_q === 1'b0)
      ev[0] <= cyc;
    if (wake === 1'b0 && wk_q === 1'b1)
      ev[1] <= cyc - ev[0];
    if (rst_n === 1'b0 && rs_q === 1'b1)
      ev[2] <= cyc;
    if (rst_n === 1'b1 && rs_q === 1'b0)
      ev[3] <= cyc;
  end

  task automatic stop_test();
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
    end
  endtask

  // one oscillator tick of slack for the free running divider
  task automatic near(input string nm, input int seen, input int exp);
    check(nm, 32'(seen >= exp - TK && seen <= exp + TK), 32'h1);
  endtask

  task automatic wait_ev(input int k, input int lim);
    int v0;
    v0 = ev[k];
    repeat (lim)
      if (ev[k] == v0)
        @(negedge clk);
    check("event wait", 32'(ev[k] != v0), 32'h1);
  endtask

  task automatic t_startup();
    repeat (6) @(posedge clk);
    check("wake in reset", wake, 32'h0);
    check("reset_n in reset", rst_n, 32'h0);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    check("measure on", meas, 32'h1);
    check("reset_n reading", rst_n, 32'h0);
    @(posedge clk);
    pin <= 1'b1;
    repeat (4 * TK) @(negedge clk);
    check("reading aborted", meas, 32'h0);
    @(posedge clk);
    pin <= 1'b0;
    repeat (4 * TK) @(negedge clk);
    check("reading restarted", meas, 32'h1);
    check("reset_n held", rst_n, 32'h0);
    @(posedge clk);
    conv <= '{valid: 1'b1, count: 20'h0_000a};
    @(posedge clk);
    conv.valid <= 1'b0;
    repeat (2) @(negedge clk);
    check("measure off", meas, 32'h0);
    check("reset_n released", rst_n, 32'h1);
    t_cap = cyc;
  endtask

  task automatic t_period();
    int r;
    @(posedge clk);
    conv <= '{valid: 1'b1, count: 20'h0_0014};
    wait_ev(0, IV + 2 * TK);
    near("first wakeup", ev[0] - t_cap, IV);
    r = ev[0];
    wait_ev(0, IV + TK);
    check("interval", ev[0] - r, IV);
    repeat (3 * TK) @(negedge clk);
    check("wake width", ev[1], 2 * TK);
  endtask

  task automatic t_quick();
    int r;
    @(posedge clk);
    dly <= 16'h000d;
    wait_ev(0, IV + TK);
    r = ev[0];
    wait_ev(0, IV + TK);
    check("interval kept", ev[0] - r, IV);
    repeat (2 * TK) @(negedge clk);
    check("wake cut short", 32'(ev[1] < 2 * TK), 32'h1);
  endtask

  task automatic t_late();
    int r;
    @(posedge clk);
    dly <= 16'h008c;
    wait_ev(0, IV + TK);
    r = ev[0];
    wait_ev(2, IV + TK);
    check("deadline miss", ev[2] - r, IV);
    check("no wake on miss", ev[0], r);
    @(posedge clk);
    dly <= 16'h003c;
    wait_ev(0, 32 * TK + IV + 2 * TK);
    check("reset width", ev[3] - ev[2], 32 * TK);
    near("reset to wake", ev[0] - ev[2], 32 * TK + IV);
  endtask

  task automatic t_manual();
    @(posedge clk);
    pin <= 1'b1;
    repeat (10) @(posedge clk);
    pin <= 1'b0;
    repeat (4 * TK) @(negedge clk);
    check("glitch ignored", rst_n, 32'h1);
    wait_ev(0, IV + TK);
    // pin first seen high on the boundary tick, validated one tick into the wakeup
    repeat (IV - 10) @(posedge clk);
    pin <= 1'b1;
    wait_ev(0, TK);
    // still inside the natural wakeup width here
    repeat (TK + 7) @(negedge clk);
    check("manual reset", rst_n, 32'h0);
    check("wake forced low", wake, 32'h0);
    repeat (8 * TK) @(negedge clk);
    check("reset held", rst_n, 32'h0);
    @(posedge clk);
    pin <= 1'b0;
    t_rel = cyc;
    wait_ev(3, 36 * TK);
    near("release to reset end", ev[3] - t_rel, 34 * TK);
    wait_ev(0, IV + 2 * TK);
    near("restart", ev[0] - ev[3], IV);
  endtask

  initial
  begin
    t_startup();
    t_period();
    t_quick();
    t_late();
    t_manual();
    stop_test();
  end

  initial
  begin
    #(20_000 * 8);
    err_count++;
    stop_test();
  end
endmodule
